// ### src/isq_responder.v
// Purpose: answers position, current and input status queries at once
// Assumes: command bytes and reply bytes come from same-clock link logic
// Notes: lines are CR terminated; other lines are handed to the queue
// Operation
// - hold signed 32-bit position, return on query
// - hex position is exactly eight characters
// - decimal position is full signed range
// - servo current query returns 0.01 A value
// - queries answered immediately, never queued; code drops a query whose CR arrives while a reply is being prepared or sent
// - closed input is 0, open is 1
// - positions without an input read 0
// - basic variant: main inputs one-seven plus index
// - expansion: selector picks main, else top
// - other variants ignore trailing selector
// - eight-input variant gives nine positions
// - stepper: step, direction, enable plus index
// - energized circuit is low, closed
// - L means low, H means high
// - format setting picks hex or decimal
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "isq_defines.vh"

module isq_responder (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_ff,
    // command bytes in
    input wire rx_valid,
    input wire [7:0] rx_data,
    // reply bytes out
    output wire tx_valid,
    output reg [7:0] tx_data_ff,
    input wire tx_ready,
    // lines that belong to the buffered queue
    output reg queue_line_ff,
    // measured values
    input wire [31:0] position,
    input wire [15:0] current_rms,
    // input pins, high while energized
    input wire [7:0] main_in_energized,
    input wire [7:0] top_in_energized,
    input wire [2:0] stp_in_energized,
    input wire index_energized
);

localparam S_IDLE = 3'h0;
localparam S_PREP = 3'h1;
localparam S_CONV = 3'h2;
localparam S_HDR = 3'h3;
localparam S_SIGN = 3'h4;
localparam S_VAL = 3'h5;
localparam S_CR = 3'h6;

reg [4:0] ctrl_ff;
reg [15:0] cnt_ff;
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [1:0] hdr_ff;
reg [1:0] nxt_hdr;
reg [3:0] dig_ff;
reg [3:0] nxt_dig;
reg [7:0] nxt_char;
reg [1:0] kind_ff;
reg fmt_hex_ff;
reg [31:0] val_ff;
reg [7:0] c0_ff;
reg [7:0] c1_ff;
reg [7:0] c2_ff;
reg [1:0] len_ff;
reg [19:0] sync1_ff;
reg [19:0] sync2_ff;

wire hex_mode;
wire [1:0] variant;
wire conv_done;
wire conv_neg;
wire [39:0] bcd;
wire [8:0] in_bits;
wire [3:0] in_last;
wire [3:0] lead;
wire [3:0] start_dig;
wire line_end;
wire is_pos;
wire is_cur;
wire is_inp;
wire is_query;
wire send;
wire dec_path;

assign hex_mode = ctrl_ff[`ISQ_CTRL_HEX];
assign variant = ctrl_ff[`ISQ_CTRL_VAR_LO +: 2];

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        sync1_ff <= 20'h00000;
        sync2_ff <= 20'h00000;
    end else begin
        sync1_ff <= {index_energized, stp_in_energized, top_in_energized,
                     main_in_energized};
        sync2_ff <= sync1_ff;
    end
end

// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        ctrl_ff <= `ISQ_CTRL_RST;
        reg_rdata_ff <= 32'h00000000;
    end else begin
        if (reg_wr && reg_addr == `ISQ_REG_CTRL)
            ctrl_ff <= reg_wdata[4:0];
        reg_rdata_ff <= 32'h00000000;
        if (reg_rd && reg_addr == `ISQ_REG_CTRL)
            reg_rdata_ff <= {27'h0000000, ctrl_ff};
        else if (reg_rd && reg_addr == `ISQ_REG_STAT)
            reg_rdata_ff <= {cnt_ff, 13'h0000, kind_ff, state_ff != S_IDLE};
    end
end

// ----------------------------------------------------------------
// line parser
// ----------------------------------------------------------------
assign line_end = rx_valid && rx_data == `ISQ_CH_CR;
assign is_pos = len_ff == 2'h2 && c0_ff == `ISQ_CH_I && c1_ff == `ISQ_CH_P;
assign is_cur = len_ff == 2'h2 && c0_ff == `ISQ_CH_I && c1_ff == `ISQ_CH_Q &&
                ctrl_ff[`ISQ_CTRL_SERVO];
assign is_inp = c0_ff == `ISQ_CH_I && c1_ff == `ISQ_CH_S &&
                (len_ff == 2'h2 || (len_ff == 2'h3 && c2_ff == `ISQ_CH_X));
assign is_query = is_pos | is_cur | is_inp;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        c0_ff <= 8'h00;
        c1_ff <= 8'h00;
        c2_ff <= 8'h00;
        len_ff <= 2'h0;
        queue_line_ff <= 1'b0;
    end else begin
        queue_line_ff <= 1'b0;
        if (line_end) begin
            len_ff <= 2'h0;
            // non-queries, L and H parameters, queued
            queue_line_ff <= ~is_query && len_ff != 2'h0;
        end else if (rx_valid) begin
            // long lines saturate and never match a query
            if (len_ff == 2'h0)
                c0_ff <= rx_data;
            if (len_ff == 2'h1)
                c1_ff <= rx_data;
            if (len_ff == 2'h2)
                c2_ff <= rx_data;
            if (len_ff != 2'h3)
                len_ff <= len_ff + 2'h1;
            else
                c0_ff <= 8'h00;
        end
    end
end

// ----------------------------------------------------------------
// value sources
// ----------------------------------------------------------------
isq_dec_conv u_conv (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(state_ff == S_PREP && dec_path),
    .value(val_ff),
    .done_ff(conv_done),
    .neg_ff(conv_neg),
    .bcd_ff(bcd)
);

isq_in_map u_map (
    .mclk(mclk),
    .arst_n(arst_n),
    .capture(state_ff == S_IDLE && line_end && is_inp),
    .variant(variant),
    .x_sel(len_ff == 2'h3),
    .index_fitted(ctrl_ff[`ISQ_CTRL_IDX]),
    .main_in(sync2_ff[7:0]),
    .top_in(sync2_ff[15:8]),
    .stp_in(sync2_ff[18:16]),
    .index_in(sync2_ff[19]),
    .bits_ff(in_bits),
    .last_ff(in_last)
);

function [3:0] lead_of;
    input [39:0] d;
    integer i;
    begin
        lead_of = 4'h0;
        for (i = 0; i < 10; i = i + 1)
            if (d[i*4 +: 4] != 4'h0)
                lead_of = i[3:0];
    end
endfunction

function [7:0] hex_char;
    input [3:0] n;
    begin
        hex_char = (n < 4'hA) ? `ISQ_CH_ZERO + {4'h0, n} :
                   `ISQ_CH_A + {4'h0, n} - 8'h0A;
    end
endfunction

assign lead = lead_of(bcd);
assign dec_path = ~fmt_hex_ff && kind_ff != `ISQ_KIND_INP;
assign start_dig = (kind_ff == `ISQ_KIND_INP) ? in_last :
                   ~fmt_hex_ff ? lead :
                   (kind_ff == `ISQ_KIND_POS) ? `ISQ_POS_HEX_LAST : `ISQ_CUR_HEX_LAST;
assign send = state_ff == S_HDR || state_ff == S_SIGN ||
              state_ff == S_VAL || state_ff == S_CR;
assign tx_valid = send;

// ----------------------------------------------------------------
// reply sequencer
// ----------------------------------------------------------------
always @* begin
    nxt_state = state_ff;
    nxt_hdr = hdr_ff;
    nxt_dig = dig_ff;
    case (state_ff)
        S_IDLE: begin
            if (line_end && is_query)
                nxt_state = S_PREP;
        end
        S_PREP: begin
            nxt_hdr = 2'h0;
            nxt_state = dec_path ? S_CONV : S_HDR;
        end
        S_CONV: begin
            if (conv_done)
                nxt_state = S_HDR;
        end
        S_HDR: begin
            if (tx_ready) begin
                nxt_hdr = hdr_ff + 2'h1;
                nxt_dig = start_dig;
                if (hdr_ff == 2'h2)
                    nxt_state = (dec_path && conv_neg) ? S_SIGN : S_VAL;
            end
        end
        S_SIGN: begin
            if (tx_ready)
                nxt_state = S_VAL;
        end
        S_VAL: begin
            if (tx_ready) begin
                nxt_dig = dig_ff - 4'h1;
                if (dig_ff == 4'h0)
                    nxt_state = S_CR;
            end
        end
        S_CR: begin
            if (tx_ready)
                nxt_state = S_IDLE;
        end
        default: nxt_state = S_IDLE;
    endcase
end

always @* begin
    nxt_char = `ISQ_CH_CR;
    case (nxt_state)
        S_HDR: begin
            if (nxt_hdr == 2'h0)
                nxt_char = `ISQ_CH_I;
            else if (nxt_hdr == 2'h2)
                nxt_char = `ISQ_CH_EQ;
            else if (kind_ff == `ISQ_KIND_POS)
                nxt_char = `ISQ_CH_P;
            else if (kind_ff == `ISQ_KIND_CUR)
                nxt_char = `ISQ_CH_Q;
            else
                nxt_char = `ISQ_CH_S;
        end
        S_SIGN: nxt_char = `ISQ_CH_MINUS;
        S_VAL: begin
            // open reads 1, unused reads 0
            if (kind_ff == `ISQ_KIND_INP)
                nxt_char = in_bits[nxt_dig] ? `ISQ_CH_ONE : `ISQ_CH_ZERO;
            else if (fmt_hex_ff)
                nxt_char = hex_char(val_ff[{nxt_dig[2:0], 2'h0} +: 4]);
            else
                nxt_char = `ISQ_CH_ZERO + {4'h0, bcd[{nxt_dig, 2'h0} +: 4]};
        end
        default: nxt_char = `ISQ_CH_CR;
    endcase
end

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        state_ff <= S_IDLE;
        hdr_ff <= 2'h0;
        dig_ff <= 4'h0;
        tx_data_ff <= `ISQ_CH_CR;
        kind_ff <= `ISQ_KIND_POS;
        fmt_hex_ff <= 1'b1;
        val_ff <= 32'h00000000;
        cnt_ff <= 16'h0000;
    end else begin
        state_ff <= nxt_state;
        hdr_ff <= nxt_hdr;
        dig_ff <= nxt_dig;
        tx_data_ff <= nxt_char;
        if (state_ff == S_IDLE && line_end && is_query) begin
            fmt_hex_ff <= hex_mode;
            if (is_pos) begin
                kind_ff <= `ISQ_KIND_POS;
                val_ff <= position;
            end else if (is_cur) begin
                kind_ff <= `ISQ_KIND_CUR;
                val_ff <= {{16{current_rms[15]}}, current_rms};
            end else begin
                kind_ff <= `ISQ_KIND_INP;
            end
        end
        if (state_ff == S_CR && tx_ready)
            cnt_ff <= cnt_ff + 16'h0001;
    end
end

endmodule
`default_nettype wire

// ### shared/isq_defines.vh
// Purpose: constants of the immediate status query responder
// Assumes: 32-bit register data, byte-wide command and reply streams
// Notes: offsets are byte addresses on the plain register port
`ifndef ISQ_DEFINES_VH
`define ISQ_DEFINES_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ISQ_REG_CTRL 4'h0
`define ISQ_REG_STAT 4'h4
`define ISQ_CTRL_HEX 0
`define ISQ_CTRL_VAR_LO 1
`define ISQ_CTRL_IDX 3
`define ISQ_CTRL_SERVO 4
`define ISQ_CTRL_RST 5'h19
`define ISQ_STAT_BUSY 0
`define ISQ_STAT_KIND_LO 1
`define ISQ_STAT_CNT_LO 16

// ----------------------------------------------------------------
// variants
// ----------------------------------------------------------------
`define ISQ_VAR_BASIC 2'h0
`define ISQ_VAR_EXPAN 2'h1
`define ISQ_VAR_EIGHT 2'h2
`define ISQ_VAR_STEP 2'h3

// ----------------------------------------------------------------
// query kinds and characters
// ----------------------------------------------------------------
`define ISQ_KIND_POS 2'h0
`define ISQ_KIND_CUR 2'h1
`define ISQ_KIND_INP 2'h2
`define ISQ_CH_I 8'h49
`define ISQ_CH_P 8'h50
`define ISQ_CH_Q 8'h51
`define ISQ_CH_S 8'h53
`define ISQ_CH_X 8'h58
`define ISQ_CH_EQ 8'h3D
`define ISQ_CH_CR 8'h0D
`define ISQ_CH_MINUS 8'h2D
`define ISQ_CH_ZERO 8'h30
`define ISQ_CH_ONE 8'h31
`define ISQ_CH_A 8'h41

// ----------------------------------------------------------------
// reply lengths (last digit index) and decimal shift count
// ----------------------------------------------------------------
`define ISQ_POS_HEX_LAST 4'h7
`define ISQ_CUR_HEX_LAST 4'h3
`define ISQ_DEC_SHIFTS 6'h20

`endif

// ### src/isq_dec_conv.v
// Purpose: signed 32-bit binary to ten BCD digits, one bit per clock
// Assumes: start is a one-cycle pulse while idle
// Notes: done pulses 33 cycles after start; outputs hold until next start
`timescale 1ns/1ns
`default_nettype none
`include "isq_defines.vh"

module isq_dec_conv (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // request
    input wire start,
    input wire [31:0] value,
    // result
    output reg done_ff,
    output reg neg_ff,
    output reg [39:0] bcd_ff
);

reg [31:0] mag_ff;
reg [5:0] cnt_ff;
reg run_ff;
wire [39:0] adj;

// ----------------------------------------------------------------
// add three to every digit above four before each shift
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 10; g = g + 1) begin : g_adj
        assign adj[g*4 +: 4] = (bcd_ff[g*4 +: 4] > 4'h4) ?
                               bcd_ff[g*4 +: 4] + 4'h3 : bcd_ff[g*4 +: 4];
    end
endgenerate

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        mag_ff <= 32'h00000000;
        cnt_ff <= 6'h00;
        run_ff <= 1'b0;
        done_ff <= 1'b0;
        neg_ff <= 1'b0;
        bcd_ff <= 40'h0000000000;
    end else begin
        done_ff <= 1'b0;
        if (start) begin
            // magnitude of the most negative value still fits unsigned
            mag_ff <= value[31] ? (~value + 32'h00000001) : value;
            neg_ff <= value[31];
            bcd_ff <= 40'h0000000000;
            cnt_ff <= 6'h00;
            run_ff <= 1'b1;
        end else if (run_ff) begin
            bcd_ff <= {adj[38:0], mag_ff[31]};
            mag_ff <= {mag_ff[30:0], 1'b0};
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == `ISQ_DEC_SHIFTS - 6'h01) begin
                run_ff <= 1'b0;
                done_ff <= 1'b1;
            end
        end
    end
end

endmodule
`default_nettype wire

// ### src/isq_in_map.v
// Purpose: snapshot of input status positions for the input query
// Assumes: pin levels already synchronised, high while energized
// Notes: bit 0 is the rightmost reply character
`timescale 1ns/1ns
`default_nettype none
`include "isq_defines.vh"

module isq_in_map (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // control
    input wire capture,
    input wire [1:0] variant,
    input wire x_sel,
    input wire index_fitted,
    // synchronised pins
    input wire [7:0] main_in,
    input wire [7:0] top_in,
    input wire [2:0] stp_in,
    input wire index_in,
    // snapshot
    output reg [8:0] bits_ff,
    output reg [3:0] last_ff
);

reg [8:0] nxt_bits;
reg [3:0] nxt_last;
wire idx_open;

// not fitted index reads as unused position
assign idx_open = index_fitted & ~index_in;

always @* begin
    nxt_bits = 9'h000;
    nxt_last = 4'h7;
    case (variant)
        `ISQ_VAR_EXPAN: begin
            if (x_sel)
                nxt_bits = {1'b0, idx_open, ~main_in[6:0]};
            else
                nxt_bits = {1'b0, ~top_in};
        end
        `ISQ_VAR_EIGHT: begin
            nxt_bits = {idx_open, ~main_in};
            nxt_last = 4'h8;
        end
        `ISQ_VAR_STEP: begin
            nxt_bits = {1'b0, idx_open, 4'h0, ~stp_in};
        end
        default: begin
            nxt_bits = {1'b0, idx_open, ~main_in[6:0]};
        end
    endcase
end

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        bits_ff <= 9'h000;
        last_ff <= 4'h7;
    end else if (capture) begin
        bits_ff <= nxt_bits;
        last_ff <= nxt_last;
    end
end

endmodule
`default_nettype wire

// ### verification/isq_responder_checker.sv
// Purpose: port assertions of the status query responder
// Assumes: one clock, asynchronous active-low reset
// Notes: name letters and equals sign never occur among value characters
`timescale 1ns/1ns
`default_nettype none
`include "isq_defines.vh"
module isq_responder_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    // command and reply link
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data_ff,
    input wire logic tx_ready,
    input wire logic queue_line_ff
);
    logic [5:0] since_cr_ff;
    logic [5:0] nxt_since_cr;
    logic take;
    assign take = tx_valid && tx_ready;
    // saturates so an idle link never wraps into a false match
    assign nxt_since_cr = (rx_valid && rx_data == `ISQ_CH_CR) ? 6'h00 :
        (since_cr_ff == 6'h3F) ? 6'h3F : since_cr_ff + 6'h01;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            since_cr_ff <= 6'h3F;
        end else begin
            since_cr_ff <= nxt_since_cr;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
        else $error("read data outside a read answer");
    a_unmapped_zero: assert property ($past(reg_rd) && !($past(reg_addr) inside {4'h0, 4'h4})
        |-> reg_rdata_ff == 32'h0) else $error("unmapped read not zero");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data_ff))
        else $error("reply byte dropped before acceptance");
    a_first_char: assert property ($rose(tx_valid) |-> tx_data_ff == `ISQ_CH_I)
        else $error("reply does not open with name");
    a_name_letter: assert property (take && tx_data_ff == `ISQ_CH_I |=>
        tx_data_ff inside {`ISQ_CH_P, `ISQ_CH_Q, `ISQ_CH_S}) else $error("bad name letter");
    a_equals_next: assert property (take && tx_data_ff inside {`ISQ_CH_P, `ISQ_CH_Q,
        `ISQ_CH_S} |=> tx_data_ff == `ISQ_CH_EQ) else $error("equals sign missing");
    a_end_falls: assert property (take && tx_data_ff == `ISQ_CH_CR |=> !tx_valid)
        else $error("reply continues after terminator");
    a_prompt_reply: assert property ($rose(tx_valid) |-> since_cr_ff <= 6'h28)
        else $error("reply not immediate");
    a_queue_pulse: assert property (queue_line_ff |-> since_cr_ff <= 6'h01
        ##1 !queue_line_ff) else $error("queue hand-off late or long");
    c_reply: cover property ($rose(tx_valid));
    c_stalled: cover property (tx_valid && !tx_ready);
    c_queued: cover property (queue_line_ff);
endmodule
bind isq_responder isq_responder_checker i_chk (.mclk(mclk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data_ff(tx_data_ff), .tx_ready(tx_ready),
    .queue_line_ff(queue_line_ff));
`default_nettype wire

// ### verification/isq_host_model.sv
// Purpose: host controller sending command lines and taking replies
// Assumes: same clock as the responder
// Notes: stall accepts one byte in three; idle data is inverted noise
`timescale 1ns/1ns
`default_nettype none
module isq_host_model (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // reply side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data_ff,
    input wire logic stall,
    output logic tx_ready,
    output logic reply_stb,
    output logic [127:0] reply_line,
    // command side
    output logic rx_valid,
    output logic [7:0] rx_data
);
    logic [1:0] ph_ff;
    logic [127:0] line_ff;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // host sends no level parameters, only the lines IP, IQ, IS, ISX and IPX
    task automatic send(input string s);
        foreach (s[i]) begin
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_data <= s[i];
            @(posedge mclk);
            rx_valid <= 1'b0;
            rx_data <= ~s[i];
        end
    endtask
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ph_ff <= 2'h0;
            tx_ready <= 1'b0;
            line_ff <= 128'h0;
            reply_stb <= 1'b0;
            reply_line <= 128'h0;
        end else begin
            ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
            tx_ready <= !stall || ph_ff == 2'h2;
            reply_stb <= 1'b0;
            if (tx_valid && tx_ready) begin
                line_ff <= (tx_data_ff == 8'h0D) ? 128'h0 : {line_ff[119:0], tx_data_ff};
                reply_stb <= (tx_data_ff == 8'h0D);
                reply_line <= {line_ff[119:0], tx_data_ff};
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/isq_responder_test.sv
// Purpose: self-checking bench of the status query responder
// Assumes: host model carries the command link
// Notes: expected lines queue up and are compared as replies complete
`timescale 1ns/1ns
`default_nettype none
module isq_responder_test;
    logic mclk, arst_n, reg_wr, reg_rd, rx_valid, tx_valid, tx_ready, queue_line_ff;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_ff, position, rnd, val;
    logic [7:0] rx_data, tx_data_ff, main_in_energized, top_in_energized;
    logic [15:0] current_rms, n_rep;
    logic [2:0] stp_in_energized;
    logic index_energized, stall, reply_stb, rd_pend;
    logic [127:0] reply_line;
    logic [1:0] last_kind;
    logic [127:0] exp_q[$];
    logic [31:0] reg_q[$];
    string cmd;
    int mismatches, n_checks, cyc;
    isq_responder i_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data_ff(tx_data_ff),
        .tx_ready(tx_ready), .queue_line_ff(queue_line_ff), .position(position),
        .current_rms(current_rms), .main_in_energized(main_in_energized),
        .top_in_energized(top_in_energized), .stp_in_energized(stp_in_energized),
        .index_energized(index_energized));
    isq_host_model i_host (.mclk(mclk), .arst_n(arst_n), .tx_valid(tx_valid),
        .tx_data_ff(tx_data_ff), .stall(stall), .tx_ready(tx_ready), .reply_stb(reply_stb),
        .reply_line(reply_line), .rx_valid(rx_valid), .rx_data(rx_data));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [127:0] pk(input string s);
        logic [127:0] r;
        r = 128'h0;
        foreach (s[i]) r = {r[119:0], s[i]};
        return r;
    endfunction
    function automatic string fv(input string nm, input logic hx, input logic [31:0] v,
        input logic wide);
        string s;
        if (hx) s = wide ? $sformatf("%s=%08h", nm, v) : $sformatf("%s=%04h", nm, v[15:0]);
        else s = $sformatf("%s=%0d", nm, $signed(v));
        return s.toupper();
    endfunction
    // energized reads 0, open 1, unused 0
    function automatic string inp(input logic [1:0] v, input logic x, input logic ix);
        logic [8:0] e;
        logic [8:0] u;
        string s;
        e = {1'b0, index_energized, main_in_energized[6:0]};
        u = {1'b0, ix, 7'h7F};
        if (v == 2'h1 && !x) begin
            e = {1'b0, top_in_energized};
            u = 9'h0FF;
        end
        if (v == 2'h2) begin
            e = {index_energized, main_in_energized};
            u = {ix, 8'hFF};
        end
        if (v == 2'h3) begin
            e = {1'b0, index_energized, 4'h0, stp_in_energized};
            u = {1'b0, ix, 7'h07};
        end
        s = "IS=";
        for (int i = (v == 2'h2) ? 8 : 7; i >= 0; i--) s = {s, (u[i] && !e[i]) ? "1" : "0"};
        return s;
    endfunction
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        if (!w) reg_q.push_back(d);
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic ask(input string c, input string exp);
        if (exp == "") exp_q.push_back(128'h1);
        else begin
            exp_q.push_back(pk({exp, "\r"}));
            n_rep++;
            last_kind = (c[1] == "P") ? 2'h0 : (c[1] == "Q") ? 2'h1 : 2'h2;
        end
        i_host.send({c, "\r"});
    endtask
    task automatic settle;
        int k;
        k = 0;
        while ((exp_q.size() != 0 || tx_valid !== 1'b0) && k < 400) begin
            @(posedge mclk);
            k++;
        end
        repeat (3) @(posedge mclk);
    endtask
    task automatic q(input string c, input string exp);
        ask(c, exp);
        settle;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            test_done;
        end
        if (reply_stb) chk(reply_line, exp_q.size() != 0 ? exp_q.pop_front() : 128'hX);
        if (queue_line_ff) chk(128'h1, exp_q.size() != 0 ? exp_q.pop_front() : 128'hX);
        if (rd_pend) chk(reg_rdata_ff, reg_q.size() != 0 ? reg_q.pop_front() : 32'hX);
        rd_pend <= reg_rd;
    end
    initial begin
        {arst_n, reg_wr, reg_rd, stall, rd_pend, index_energized} = 6'h00;
        {reg_addr, reg_wdata, position, current_rms} = 84'h0;
        {main_in_energized, top_in_energized, stp_in_energized} = 19'h0;
        {n_rep, last_kind, mismatches, n_checks, cyc} = 0;
        rnd = 32'he59c7d3a;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        acc(1'b0, 4'h0, 32'h19);
        acc(1'b0, 4'h4, 32'h0);
        acc(1'b1, 4'h8, 32'hFFFFFFFF);
        acc(1'b0, 4'h8, 32'h0);
        acc(1'b1, 4'h0, 32'hFFFFFFF9);
        acc(1'b0, 4'h0, 32'h19);
        position <= 32'h00002710;
        q("IP", "IP=00002710");
        position <= 32'hFFFFD8F0;
        q("IP", "IP=FFFFD8F0");
        acc(1'b0, 4'h4, 32'h00020000);
        // range ends and random values in both formats
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            val = (i < 2) ? 32'h7FFFFFFF : (i < 4) ? 32'h80000000 : (i < 6) ? 32'h0 : rnd;
            acc(1'b1, 4'h0, {27'h0, 4'hC, i[0]});
            position <= val;
            current_rms <= val[31:16];
            q("IP", fv("IP", i[0], val, 1'b1));
            q("IQ", fv("IQ", i[0], {{16{val[31]}}, val[31:16]}, 1'b0));
        end
        // no current query off servo; other lines go to the queue
        acc(1'b1, 4'h0, 32'h0000000D);
        q("IQ", "");
        q("IPX", "");
        // query during a stalled reply is dropped
        stall <= 1'b1;
        ask("IP", fv("IP", 1'b1, val, 1'b1));
        i_host.send("IS\r");
        settle;
        // every variant, selector and index setting
        for (int k = 0; k < 16; k++) begin
            rnd = lfsr(rnd);
            stall <= rnd[24];
            main_in_energized <= rnd[7:0];
            top_in_energized <= rnd[15:8];
            stp_in_energized <= rnd[18:16];
            index_energized <= rnd[19];
            acc(1'b1, 4'h0, {27'h0, 1'b1, k[3], k[1:0], rnd[25]});
            repeat (3) @(posedge mclk);
            cmd = "IS";
            if (k[2]) cmd = {cmd, "X"};
            q(cmd, inp(k[1:0], k[2], k[3]));
        end
        acc(1'b0, 4'h4, {n_rep, 13'h0, last_kind, 1'b0});
        settle;
        chk(exp_q.size(), 0);
        test_done;
    end
endmodule
`default_nettype wire
